/* File: common/ext_bus_map.svh */
// Purpose: Constants for the external parallel bus control block.
// Assumes: Included by bare name from every design file that needs it.
// Notes: Address decode values and internal memory geometry.
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH

`define ADDR_W 32
`define DATA_W 64
`define HALF_W 32
`define BANK_FIELD_HI 31
`define BANK_FIELD_LO 26
`define BANK0_CODE 6'h02
`define BANK1_CODE 6'h03
`define HOST_FIELD_HI 31
`define HOST_FIELD_LO 28
`define HOST_LOCAL_CODE 4'h0
`define MEM_IDX_W 6
`define MEM_WORDS 64
`define FIFO_DEPTH 8
`define FIFO_PTR_W 3
`define SLAVE_WAIT_CYCLES 2'h1
`define ACK_BLIND_CYCLES 3'h5
`define BOOT_LIMIT_W 8
`define BOOT_WORDS 8'h10

`endif

/* File: common/ext_bus_pkg.sv */
// Purpose: Shared types for the external bus ends.
// Assumes: Used as ext_bus_pkg::name, never imported.
// Notes: Only types live here; numbers are in the map header.
package ext_bus_pkg;
   typedef enum logic [1:0] {
      OP_READ,
      OP_WRITE_LOW,
      OP_WRITE_HIGH,
      OP_WRITE_LONG
   } op_e;

   typedef struct packed {
      op_e op;
      logic burst;
      logic [31:0] addr;
      logic [63:0] wdata;
   } request_s;
endpackage

/* File: common/ext_bus_if.sv */
// Purpose: Shared external bus wires between the two ends.
// Assumes: One master end, one slave end; oe signals low while driving.
// Notes: Resolves each shared line from the enables; released strobes and ack read high, released address, data and burst read low.
`timescale 1ns/1ps
interface ext_bus_if;
   logic [31:0] m_addr_o;
   logic m_addr_oe_n;
   logic [63:0] m_data_o;
   logic m_data_oe_n;
   logic m_rd_n_o;
   logic m_wrl_n_o;
   logic m_wrh_n_o;
   logic m_ctl_oe_n;
   logic m_burst_o;
   logic bank0_select_n;
   logic bank1_select_n;
   logic host_space_select_n;
   logic boot_mem_select_n;
   logic boot_mem_select_oe_n;
   logic [63:0] s_data_o;
   logic s_data_oe_n;
   logic s_ack_o;
   logic s_ack_oe_n;
   logic [31:0] ext_address_bus;
   logic [63:0] ext_data_bus;
   logic read_strobe_n;
   logic write_low_strobe_n;
   logic write_high_strobe_n;
   logic burst_flag;
   logic ack;

   // Wire resolution; undriven strobes and ack float high, undriven address, data and burst lines read low
   assign ext_address_bus = m_addr_oe_n ? 32'h0 : m_addr_o;
   assign ext_data_bus = !m_data_oe_n ? m_data_o : (!s_data_oe_n ? s_data_o : 64'h0);
   assign read_strobe_n = m_ctl_oe_n ? 1'b1 : m_rd_n_o;
   assign write_low_strobe_n = m_ctl_oe_n ? 1'b1 : m_wrl_n_o;
   assign write_high_strobe_n = m_ctl_oe_n ? 1'b1 : m_wrh_n_o;
   assign burst_flag = m_ctl_oe_n ? 1'b0 : m_burst_o;
   assign ack = s_ack_oe_n ? 1'b1 : s_ack_o;

   modport master (
      output m_addr_o, m_addr_oe_n, m_data_o, m_data_oe_n, m_rd_n_o, m_wrl_n_o, m_wrh_n_o,
      output m_ctl_oe_n, m_burst_o, bank0_select_n, bank1_select_n, host_space_select_n,
      output boot_mem_select_n, boot_mem_select_oe_n,
      input ext_data_bus, ack
   );
   modport slave (
      output s_data_o, s_data_oe_n, s_ack_o, s_ack_oe_n,
      input ext_address_bus, ext_data_bus, read_strobe_n, write_low_strobe_n, write_high_strobe_n,
      input burst_flag
   );
endinterface

/* File: core/req_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Full and empty come from an occupancy counter.
`timescale 1ns/1ps
module req_fifo #(
   parameter int WIDTH = 130,
   parameter int DEPTH = 8,
   parameter int PTR_W = 3
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [PTR_W:0] cnt_q, cnt_d;
   logic push, pop;

   // Count is one bit wider than the pointers so that full is distinct from empty
   assign in_ready = (cnt_q != (PTR_W+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer arithmetic wraps naturally because depth is a power of two
   always_comb begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage has no reset; only valid entries are ever read
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
endmodule // req_fifo

/* File: core/bus_master_end.sv */
// Purpose: Bus master end: issues reads and writes on the external bus.
// Assumes: Requests arrive on a valid/ready port and queue in a FIFO.
// Notes: Address, strobes and bank/host selects all change on the same edge.
`timescale 1ns/1ps
`include "ext_bus_map.svh"

module bus_master_end (
   input wire logic core_clk,
   input wire logic reset,
   ext_bus_if.master bus,
   input wire logic bus_owner,
   input wire logic zone_32bit,
   input wire logic eprom_boot_strap,
   input wire logic boot_active,
   output logic boot_mode_q,
   input wire logic req_valid,
   output logic req_ready,
   input wire ext_bus_pkg::request_s req,
   output logic rsp_valid_q,
   output logic [63:0] rsp_rdata_q,
   output logic busy
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ADDR,
      ST_DATA
   } mstate_e;

   mstate_e st_q, st_d;
   ext_bus_pkg::request_s cur_q, cur_d;
   ext_bus_pkg::request_s fifo_out;
   logic fifo_valid, fifo_pop;
   logic rsp_valid_d;
   logic [63:0] rsp_rdata_d;
   logic ack_s1_q, ack_s2_q;
   logic strap_s1_q, strap_s2_q;
   logic boot_mode_d;
   logic in_cycle;
   logic reset_q;
   logic [2:0] dly_q, dly_d;

   // Decode of the address field used for bank selection
   function automatic logic bank_hit(input logic [31:0] a, input logic [5:0] code);
      return a[`BANK_FIELD_HI:`BANK_FIELD_LO] == code;
   endfunction

   req_fifo #(.WIDTH($bits(ext_bus_pkg::request_s)), .DEPTH(`FIFO_DEPTH), .PTR_W(`FIFO_PTR_W)) u_fifo (
      .core_clk(core_clk),
      .reset(reset),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data(req),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out)
   );

   assign in_cycle = (st_q != ST_IDLE);
   assign busy = in_cycle;

   // Sequencer: address phase one cycle, data phase waits on synchronised ack
   always_comb begin
      st_d = st_q;
      cur_d = cur_q;
      fifo_pop = 1'b0;
      rsp_valid_d = 1'b0;
      rsp_rdata_d = rsp_rdata_q;
      dly_d = (dly_q != 3'h0) ? dly_q - 3'h1 : dly_q;
      unique case (st_q)
         ST_IDLE: begin
            // Stalls the FIFO while the bus is not ours, so it really fills
            if (fifo_valid && bus_owner) begin
               fifo_pop = 1'b1;
               cur_d = fifo_out;
               st_d = ST_ADDR;
            end
         end
         ST_ADDR: begin
            st_d = ST_DATA;
            dly_d = `ACK_BLIND_CYCLES;
         end
         ST_DATA: begin
            // The pulled-up ack reads high until the slave's synchronised reply reaches us
            if (ack_s2_q && dly_q == 3'h0) begin
               rsp_valid_d = 1'b1;
               if (cur_q.op == ext_bus_pkg::OP_READ) begin
                  rsp_rdata_d = bus.ext_data_bus;
               end
               // Back-to-back burst beats skip the idle cycle
               if (cur_q.burst && fifo_valid && bus_owner && fifo_out.burst) begin
                  fifo_pop = 1'b1;
                  cur_d = fifo_out;
                  st_d = ST_ADDR;
               end else begin
                  st_d = ST_IDLE;
               end
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // Strap latch: a delayed reset lets a two-cycle reset still fill the synchroniser
   always_comb begin
      boot_mode_d = reset_q ? strap_s2_q : boot_mode_q;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_q <= ST_IDLE;
         cur_q <= '0;
         dly_q <= 3'h0;
         rsp_valid_q <= 1'b0;
         rsp_rdata_q <= 64'h0;
      end else begin
         st_q <= st_d;
         cur_q <= cur_d;
         dly_q <= dly_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_rdata_q <= rsp_rdata_d;
      end
   end

   // Pin synchronisers; the ack adds two cycles of latency to each wait
   always_ff @(posedge core_clk) begin
      ack_s1_q <= bus.ack;
      ack_s2_q <= ack_s1_q;
      strap_s1_q <= eprom_boot_strap;
      strap_s2_q <= strap_s1_q;
      reset_q <= reset;
      boot_mode_q <= boot_mode_d;
   end

   // Pin drive: every strobe and bank/host select derives from cur_q and st_q, so all move on one edge
   always_comb begin
      bus.m_ctl_oe_n = !(in_cycle && bus_owner);
      bus.m_addr_oe_n = !(in_cycle && bus_owner);
      bus.m_addr_o = cur_q.addr;
      bus.m_data_o = cur_q.wdata;
      bus.m_data_oe_n = !(in_cycle && cur_q.op != ext_bus_pkg::OP_READ);
      bus.m_burst_o = cur_q.burst && in_cycle;
      bus.m_rd_n_o = !(in_cycle && cur_q.op == ext_bus_pkg::OP_READ);
      // 32-bit zones always use the low half
      bus.m_wrl_n_o = !(in_cycle && (cur_q.op == ext_bus_pkg::OP_WRITE_LOW || cur_q.op == ext_bus_pkg::OP_WRITE_LONG
         || (zone_32bit && cur_q.op != ext_bus_pkg::OP_READ)));
      bus.m_wrh_n_o = !(in_cycle && !zone_32bit && (cur_q.op == ext_bus_pkg::OP_WRITE_HIGH
         || cur_q.op == ext_bus_pkg::OP_WRITE_LONG));
      bus.bank0_select_n = !(in_cycle && bank_hit(cur_q.addr, `BANK0_CODE));
      bus.bank1_select_n = !(in_cycle && bank_hit(cur_q.addr, `BANK1_CODE));
      bus.host_space_select_n = !(in_cycle
         && cur_q.addr[`HOST_FIELD_HI:`HOST_FIELD_LO] != `HOST_LOCAL_CODE);
      // Boot select released during reset so the strap pull can be read
      bus.boot_mem_select_oe_n = reset || !bus_owner;
      bus.boot_mem_select_n = !(boot_mode_q && boot_active);
   end
endmodule // bus_master_end

/* File: core/bus_slave_end.sv */
// Purpose: Slave end: serves external reads and writes into internal memory.
// Assumes: Strobes come from another clock's logic and are synchronised.
// Notes: Memory is a small array of 64-bit words split in halves.
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module bus_slave_end (
   input wire logic core_clk,
   input wire logic reset,
   ext_bus_if.slave bus,
   output logic wr_seen_q,
   output logic [31:0] last_addr_q
);
   typedef enum logic [1:0] {
      SS_IDLE,
      SS_WAIT,
      SS_DRIVE,
      SS_HOLD
   } sstate_e;

   sstate_e st_q, st_d;
   logic [63:0] mem [`MEM_WORDS];
   logic [31:0] a_s1_q, a_s2_q;
   logic [63:0] d_s1_q, d_s2_q;
   logic [2:0] st1_q, st2_q;
   logic burst_s1_q, burst_s2_q;
   logic [`MEM_IDX_W-1:0] idx_q, idx_d;
   logic [63:0] rdata_q, rdata_d;
   logic [1:0] wait_q, wait_d;
   logic [31:0] last_addr_d;
   logic wr_seen_d, rd_act, wl_act, wh_act;

   // Strobes are active low; two-flop sync before any decode
   assign rd_act = !st2_q[0];
   assign wl_act = !st2_q[1];
   assign wh_act = !st2_q[2];

   always_comb begin
      st_d = st_q;
      idx_d = idx_q;
      rdata_d = rdata_q;
      wait_d = wait_q;
      last_addr_d = last_addr_q;
      wr_seen_d = wl_act || wh_act;
      unique case (st_q)
         SS_IDLE: begin
            if (rd_act || wl_act || wh_act) begin
               idx_d = a_s2_q[`MEM_IDX_W-1:0];
               last_addr_d = a_s2_q;
               wait_d = `SLAVE_WAIT_CYCLES;
               st_d = rd_act ? SS_WAIT : SS_HOLD;
            end
         end
         SS_WAIT: begin
            // Ack held low while the word is fetched
            rdata_d = mem[idx_q];
            if (wait_q == 2'h0) begin
               st_d = SS_DRIVE;
            end else begin
               wait_d = wait_q - 2'h1;
            end
         end
         SS_DRIVE: begin
            if (!rd_act) begin
               st_d = SS_IDLE;
            end else if (burst_s2_q) begin
               idx_d = idx_q + 1'b1;
               rdata_d = mem[idx_q + 1'b1];
            end
         end
         SS_HOLD: begin
            if (!(wl_act || wh_act)) begin
               st_d = SS_IDLE;
            end else if (burst_s2_q) begin
               idx_d = idx_q + 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      a_s1_q <= bus.ext_address_bus;
      a_s2_q <= a_s1_q;
      d_s1_q <= bus.ext_data_bus;
      d_s2_q <= d_s1_q;
      st1_q <= {bus.write_high_strobe_n, bus.write_low_strobe_n, bus.read_strobe_n};
      st2_q <= st1_q;
      burst_s1_q <= bus.burst_flag;
      burst_s2_q <= burst_s1_q;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_q <= SS_IDLE;
         idx_q <= '0;
         rdata_q <= 64'h0;
         wait_q <= 2'h0;
         last_addr_q <= 32'h0;
         wr_seen_q <= 1'b0;
      end else begin
         st_q <= st_d;
         idx_q <= idx_d;
         rdata_q <= rdata_d;
         wait_q <= wait_d;
         last_addr_q <= last_addr_d;
         wr_seen_q <= wr_seen_d;
      end
   end

   // Half-word writes commit each cycle the strobe is seen in the hold state
   always_ff @(posedge core_clk) begin
      if (st_q == SS_HOLD && wl_act) begin
         mem[idx_q][31:0] <= d_s2_q[31:0];
      end
      if (st_q == SS_HOLD && wh_act) begin
         mem[idx_q][63:32] <= d_s2_q[63:32];
      end
   end

   // Ack only driven on reads; writes leave it to the pull-up
   always_comb begin
      bus.s_ack_oe_n = !(st_q == SS_WAIT || st_q == SS_DRIVE);
      bus.s_ack_o = (st_q == SS_DRIVE);
      bus.s_data_oe_n = (st_q != SS_DRIVE);
      bus.s_data_o = rdata_q;
   end
endmodule // bus_slave_end

/* File: sim/ext_bus_monitor.sv */
// Purpose: Protocol checks on the shared external bus wires.
// Assumes: Inputs are interface signals of one clock domain.
// Notes: Selects are judged against the resolved address lines.
`timescale 1ns/1ps
module ext_bus_monitor (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic m_addr_oe_n,
   input wire logic m_ctl_oe_n,
   input wire logic m_data_oe_n,
   input wire logic s_ack_o,
   input wire logic s_ack_oe_n,
   input wire logic [31:0] ext_address_bus,
   input wire logic read_strobe_n,
   input wire logic write_low_strobe_n,
   input wire logic ack,
   input wire logic bank0_select_n,
   input wire logic bank1_select_n,
   input wire logic host_space_select_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // Decode holds only while the master drives the control pins
   property p_bank0;
      !m_ctl_oe_n && ext_address_bus[31:26] == 6'h02 |-> !bank0_select_n && bank1_select_n;
   endproperty
   a_bank0: assert property (p_bank0) else $error("bank 0 decode wrong");
   property p_bank1;
      !m_ctl_oe_n && ext_address_bus[31:26] == 6'h03 |-> !bank1_select_n && bank0_select_n;
   endproperty
   a_bank1: assert property (p_bank1) else $error("bank 1 decode wrong");
   property p_host;
      !m_ctl_oe_n && ext_address_bus[31:28] != 4'h0 |-> !host_space_select_n && bank0_select_n;
   endproperty
   a_host: assert property (p_host) else $error("host select decode wrong");
   property p_unmapped;
      !m_ctl_oe_n && ext_address_bus[31:27] == 5'h00 |-> host_space_select_n && bank0_select_n && bank1_select_n;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("select on unmapped address");
   // Address and strobes switch on the same edge
   property p_together;
      $changed(m_ctl_oe_n) |-> m_addr_oe_n == m_ctl_oe_n && (m_ctl_oe_n || !read_strobe_n || !m_data_oe_n);
   endproperty
   a_together: assert property (p_together) else $error("strobes and address out of step");
   property p_steady;
      !m_ctl_oe_n && $past(!m_ctl_oe_n) && $stable(ext_address_bus) |-> $stable(read_strobe_n)
         && $stable(write_low_strobe_n) && $stable(bank0_select_n) && $stable(bank1_select_n)
         && $stable(host_space_select_n);
   endproperty
   a_steady: assert property (p_steady) else $error("strobe moved without the address");
   property p_rd_data;
      !m_ctl_oe_n && !read_strobe_n |-> m_data_oe_n;
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("master drives data on a read");
   // Slave may still hold ack for a few cycles after a read, hence the run
   property p_wr_noack;
      (!write_low_strobe_n && read_strobe_n) [*4] |-> s_ack_oe_n;
   endproperty
   a_wr_noack: assert property (p_wr_noack) else $error("slave drives ack on a write");
   property p_wait;
      $fell(s_ack_oe_n) |-> !s_ack_o [*2] ##1 s_ack_o;
   endproperty
   a_wait: assert property (p_wait) else $error("read wait length wrong");
   property p_extend;
      !m_ctl_oe_n && !ack |=> !m_ctl_oe_n && $stable(ext_address_bus);
   endproperty
   a_extend: assert property (p_extend) else $error("access ended during wait");
endmodule // ext_bus_monitor

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench joining both bus ends.
// Assumes: Slave word index is address bits 5:0.
// Notes: A reference memory predicts each read; bursts are not exercised.
`timescale 1ns/1ps
`include "ext_bus_map.svh"
module tb_top;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic bus_owner = 1'b1;
   logic zone_32bit = 1'b0;
   logic eprom_boot_strap = 1'b0;
   logic boot_active = 1'b0;
   logic req_valid = 1'b0;
   ext_bus_pkg::request_s req = '0;
   logic req_ready, boot_mode_q, rsp_valid_q, busy, wr_seen_q, ok;
   logic [63:0] rsp_rdata_q;
   logic [31:0] last_addr_q;
   logic [63:0] mem [64];
   logic [63:0] exp_q [$];
   logic [31:0] adr_q [$];
   int kind_q [$];
   int errors = 0;
   int checked = 0;
   int n, acc, k;
   integer seed = 32'hAA0AB24D;
   logic [7:0] tops [5] = '{8'h08, 8'h0C, 8'h10, 8'h04, 8'h00};

   ext_bus_if bus ();
   bus_master_end bus_master_end_inst (.core_clk, .reset, .bus, .bus_owner, .zone_32bit, .eprom_boot_strap,
      .boot_active, .boot_mode_q, .req_valid, .req_ready, .req, .rsp_valid_q, .rsp_rdata_q, .busy);
   bus_slave_end bus_slave_end_inst (.core_clk, .reset, .bus, .wr_seen_q, .last_addr_q);
   ext_bus_monitor ext_bus_monitor_inst (.core_clk, .reset, .m_addr_oe_n(bus.m_addr_oe_n),
      .m_ctl_oe_n(bus.m_ctl_oe_n), .m_data_oe_n(bus.m_data_oe_n), .s_ack_o(bus.s_ack_o),
      .s_ack_oe_n(bus.s_ack_oe_n), .ext_address_bus(bus.ext_address_bus), .read_strobe_n(bus.read_strobe_n),
      .write_low_strobe_n(bus.write_low_strobe_n), .ack(bus.ack), .bank0_select_n(bus.bank0_select_n),
      .bank1_select_n(bus.bank1_select_n), .host_space_select_n(bus.host_space_select_n));

   // Clock at 40 MHz
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Mapped, host and unmapped tops with a chosen word index
   function automatic logic [31:0] pick(input int idx);
      pick = {tops[{$random(seed)} % 5], 18'h0, idx[5:0]};
   endfunction

   // Reference memory; accesses are serial, so push order is bus order
   task automatic model(input ext_bus_pkg::request_s r);
      int i;
      i = r.addr[5:0];
      kind_q.push_back(r.op == ext_bus_pkg::OP_READ);
      exp_q.push_back(mem[i]);
      adr_q.push_back(r.addr);
      if (r.op == ext_bus_pkg::OP_WRITE_LOW || (zone_32bit && r.op != ext_bus_pkg::OP_READ)) begin
         mem[i][31:0] = r.wdata[31:0];
      end else if (r.op == ext_bus_pkg::OP_WRITE_HIGH) begin
         mem[i][63:32] = r.wdata[63:32];
      end else if (r.op == ext_bus_pkg::OP_WRITE_LONG) begin
         mem[i] = r.wdata;
      end
   endtask

   // Hold valid and request until ready is seen at a taking edge
   task automatic send(input ext_bus_pkg::op_e op, input logic [31:0] a, input logic [63:0] d, input int lim);
      ext_bus_pkg::request_s r;
      r = '{op: op, burst: 1'b0, addr: a, wdata: d};
      @(posedge core_clk);
      req <= r;
      req_valid <= 1'b1;
      n = 0;
      ok = 1'b0;
      while (!ok && n < lim) begin
         @(negedge core_clk);
         ok = (req_ready === 1'b1);
         n++;
      end
      @(posedge core_clk);
      req_valid <= 1'b0;
      if (ok) begin
         model(r);
      end
   endtask

   task automatic drain();
      n = 0;
      while (kind_q.size() > 0 && n < 5000) begin
         @(posedge core_clk);
         n++;
      end
      check("drained", kind_q.size(), 0);
   endtask

   // Responses are looked at mid-cycle, clear of the launching edge
   always @(negedge core_clk) begin
      if (rsp_valid_q === 1'b1 && kind_q.size() > 0) begin
         k = kind_q.pop_front();
         check("wr_seen", wr_seen_q, k == 0);
         if (k != 0) begin
            check("rdata", rsp_rdata_q, exp_q[0]);
            check("slave_addr", last_addr_q, adr_q[0]);
         end
         exp_q.pop_front();
         adr_q.pop_front();
      end
   end

   initial begin
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(negedge core_clk);
      check("boot_mode", boot_mode_q, 0);
      // Known value in every word before random traffic
      for (int i = 0; i < 64; i++) begin
         send(ext_bus_pkg::OP_WRITE_LONG, pick(i), {$random(seed), $random(seed)}, 400);
      end
      for (int i = 0; i < 80; i++) begin
         send(ext_bus_pkg::op_e'(2'($random(seed))), pick($random(seed)), {$random(seed), $random(seed)},
            400);
         check("taken", ok, 1);
      end
      drain();
      // Without bus ownership the queue fills and then refuses
      bus_owner <= 1'b0;
      acc = 0;
      for (int i = 0; i < 10; i++) begin
         send(ext_bus_pkg::OP_READ, pick(i), 64'h0, 4);
         acc += ok;
      end
      check("fifo_fill", acc, `FIFO_DEPTH);
      check("ctl_idle", bus.m_ctl_oe_n, 1);
      bus_owner <= 1'b1;
      drain();
      // Narrow zone writes only the low half
      zone_32bit <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         send(i[0] ? ext_bus_pkg::OP_WRITE_LONG : ext_bus_pkg::OP_WRITE_LOW, pick(i),
            {$random(seed), $random(seed)}, 400);
         send(ext_bus_pkg::OP_READ, pick(i), 64'h0, 400);
      end
      drain();
      // Second reset with the strap set, then a boot sequence
      eprom_boot_strap <= 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      boot_active <= 1'b1;
      repeat (3) @(negedge core_clk);
      check("boot_mode", boot_mode_q, 1);
      check("boot_sel", bus.boot_mem_select_n, 0);
      @(posedge core_clk);
      boot_active <= 1'b0;
      repeat (3) @(negedge core_clk);
      check("boot_sel", bus.boot_mem_select_n, 1);
      stop_test();
   end

   // Watchdog well beyond the expected run of under two thousand cycles
   initial begin
      repeat (30000) @(posedge core_clk);
      check("watchdog", 1, 0);
      stop_test();
   end
endmodule // tb_top
